// ==== core/hci_status_pkg.sv ====
// Purpose: Shared constants for the status-parameter command group.
// Assumes: One 50 MHz system clock; connection slots map to handles 0..NUM_CONN-1.
// Notes:   Widths and codes are fixed; nothing here is a run-time setting.
package hci_status_pkg;

  // ----------------------------------------------------------------
  // Command encoding
  // ----------------------------------------------------------------
  localparam int OPCODE_W = 16;
  localparam int OGF_LSB = 10;
  localparam int OGF_W = 6;
  localparam int OCF_W = 10;
  localparam logic [5:0] OGF_STATUS = 6'h05;
  localparam logic [9:0] OCF_READ_FAIL_CNT = 10'h001;
  localparam logic [9:0] OCF_RESET_FAIL_CNT = 10'h002;
  localparam logic [9:0] OCF_LINK_QUALITY = 10'h003;
  // Arbitrary code for the signal-strength query
  localparam logic [9:0] OCF_SIGNAL_STRENGTH = 10'h005;

  // ----------------------------------------------------------------
  // Connection handles
  // ----------------------------------------------------------------
  localparam int HANDLE_W = 16;
  localparam int HANDLE_BITS = 12;
  localparam logic [11:0] HANDLE_MAX_VALID = 12'h0EFF;
  localparam int NUM_CONN = 4;
  localparam int SLOT_W = 2;
  localparam logic [11:0] HANDLE_SLOTS = 12'h004;

  // ----------------------------------------------------------------
  // Status codes and return values
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_SUCCESS = 8'h00;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
  localparam logic [7:0] ST_NO_CONNECTION = 8'h02;
  localparam logic [7:0] ST_BAD_PARAM = 8'h12;
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Golden receive range, dBm, two's complement
  // ----------------------------------------------------------------
  localparam logic signed [7:0] GOLDEN_LOW_DBM = 8'shC4;
  localparam logic signed [7:0] GOLDEN_HIGH_DBM = 8'shD8;
  localparam logic signed [8:0] DB_POS_LIMIT = 9'sh07F;

  typedef enum {
    ST_IDLE,
    ST_EXEC,
    ST_DONE
  } ctrl_state_t;

endpackage : hci_status_pkg

// ==== core/fail_cnt_if.sv ====
// Purpose: Link between the command sequencer and the failed-contact counter bank.
// Assumes: Same clock on both sides.
// Notes:   Clear is a one-cycle pulse; the count is combinational from the bank.
`timescale 1ns/1ps
interface fail_cnt_if;
  logic clr;
  logic [hci_status_pkg::SLOT_W-1:0] sel;
  logic [hci_status_pkg::COUNT_W-1:0] count;

  modport bank (
    input clr,
    input sel,
    output count
  );

  modport ctrl (
    output clr,
    output sel,
    input count
  );
endinterface : fail_cnt_if

// ==== core/fail_cnt_bank.sv ====
// Purpose: One failed-contact counter per connection slot.
// Assumes: Baseband event strobes come from logic on the same clock.
// Notes:   Counters saturate rather than wrap.
`timescale 1ns/1ps
module fail_cnt_bank (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [hci_status_pkg::NUM_CONN-1:0] i_flush,
  input wire logic [hci_status_pkg::NUM_CONN-1:0] i_ack,
  input wire logic [hci_status_pkg::NUM_CONN-1:0] i_new_conn,
  fail_cnt_if.bank cnt_if
);

  logic [hci_status_pkg::COUNT_W-1:0] cnt_reg [hci_status_pkg::NUM_CONN];
  logic [hci_status_pkg::COUNT_W-1:0] cnt_next [hci_status_pkg::NUM_CONN];

  always_comb
  begin
    for (int i = 0; i < hci_status_pkg::NUM_CONN; i++)
    begin
      logic zero_it;
      zero_it = 1'b0;
      cnt_next[i] = cnt_reg[i];
      if (i_new_conn[i] || (i_ack[i] && (cnt_reg[i] != hci_status_pkg::COUNT_ZERO)))
      begin
        zero_it = 1'b1;
      end
      if (cnt_if.clr && (cnt_if.sel == i[hci_status_pkg::SLOT_W-1:0]))
      begin
        zero_it = 1'b1;
      end
      if (zero_it)
      begin
        cnt_next[i] = hci_status_pkg::COUNT_ZERO;
      end
      // count flushed packet
      // A flush in an ack or reset-command clearing cycle still counts, so the event is not lost; a new link drops it
      if (i_flush[i] && !i_new_conn[i])
      begin
        if (zero_it)
        begin
          cnt_next[i] = 16'h0001;
        end
        else if (cnt_reg[i] != hci_status_pkg::COUNT_MAX)
        begin
          cnt_next[i] = cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int i = 0; i < hci_status_pkg::NUM_CONN; i++)
      begin
        cnt_reg[i] <= 16'h0000;
      end
    end
    else if (i_clk_en)
    begin
      for (int i = 0; i < hci_status_pkg::NUM_CONN; i++)
      begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  assign cnt_if.count = cnt_reg[cnt_if.sel];

endmodule : fail_cnt_bank

// ==== core/rssi_golden_cmp.sv ====
// Purpose: Express a received level relative to the golden receive range.
// Assumes: Input is a signed dBm estimate from the radio.
// Notes:   Purely combinational; result saturates at +127 dB.
`timescale 1ns/1ps
module rssi_golden_cmp (
  input wire logic signed [7:0] i_level_dbm,
  output logic signed [7:0] o_rel_db
);

  logic signed [8:0] above;
  logic signed [8:0] below;

  always_comb
  begin
    above = 9'(i_level_dbm) - 9'(hci_status_pkg::GOLDEN_HIGH_DBM);
    below = 9'(i_level_dbm) - 9'(hci_status_pkg::GOLDEN_LOW_DBM);
    o_rel_db = 8'sh00;
    if (i_level_dbm > hci_status_pkg::GOLDEN_HIGH_DBM)
    begin
      o_rel_db = (above > hci_status_pkg::DB_POS_LIMIT) ? 8'sh7F : above[7:0];
    end
    else if (i_level_dbm < hci_status_pkg::GOLDEN_LOW_DBM)
    begin
      // Below side never exceeds -68 dB, so no clip needed
      o_rel_db = below[7:0];
    end
  end

endmodule : rssi_golden_cmp

// ==== core/hci_status_cmds.sv ====
// Purpose: Executes the status-parameter commands and emits completion events.
// Assumes: Command, baseband and radio inputs come from logic on i_clk_sys.
// Notes:   One command in flight; ready drops while a command is executing.
//
// Summary of operation
// - Group field 0x05 selects this command group.
// - Opcode 0x0001 reads the counter, returns status, handle, count.
// - Count returned is two bytes, consecutive failures on that link.
// - Handles use low 12 bits; 0x0F00 to 0x0FFF are reserved.
// - Each flush after timeout adds one to that link's counter; the code drops a flush in a new-link cycle and holds the count at 0xFFFF.
// - Counter cleared on new link, ack while nonzero, or reset command.
// - Opcode 0x0002 resets the counter, returns status and handle.
// - Status byte first: zero on success, nonzero error code otherwise.
// - The handle acted on is echoed in the return.
// - Each completed command raises completion event unless masked.
// - Opcode 0x0003 returns one unsigned quality byte, higher is better.
// - Quality derivation is ours; any measure keeping the ordering.
// - Strength: positive above range, negative below, zero inside, in dB.
// - Must at least classify strength as inside, above or below.
// - Strength result is one signed byte, -128 to 127.
`timescale 1ns/1ps
module hci_status_cmds (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_opcode,
  input wire logic [15:0] i_cmd_handle,
  input wire logic i_evt_complete_en,
  input wire logic [3:0] i_conn_active,
  input wire logic [3:0] i_conn_is_acl,
  input wire logic [3:0] i_flush,
  input wire logic [3:0] i_ack,
  input wire logic [3:0] i_new_conn,
  input wire logic [31:0] i_link_quality,
  input wire logic [31:0] i_rssi_dbm,
  output logic o_cmd_ready,
  output logic o_cmd_done,
  output logic o_evt_valid,
  output logic [15:0] o_evt_opcode,
  output logic [7:0] o_evt_status,
  output logic [15:0] o_evt_handle,
  output logic [15:0] o_evt_value,
  output logic [1:0] o_evt_value_len
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hci_status_pkg::ctrl_state_t state_reg;
  hci_status_pkg::ctrl_state_t state_next;
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic [15:0] op_reg;
  logic [15:0] op_next;
  logic [15:0] handle_reg;
  logic [15:0] handle_next;

  logic evt_valid_reg;
  logic evt_valid_next;
  logic [15:0] evt_opcode_reg;
  logic [15:0] evt_opcode_next;
  logic [7:0] evt_status_reg;
  logic [7:0] evt_status_next;
  logic [15:0] evt_handle_reg;
  logic [15:0] evt_handle_next;
  logic [15:0] evt_value_reg;
  logic [15:0] evt_value_next;
  logic [1:0] evt_len_reg;
  logic [1:0] evt_len_next;

  logic [5:0] op_group;
  logic [9:0] op_cmd;
  logic [11:0] handle_id;
  logic [1:0] slot;
  logic handle_reserved;
  logic handle_known;
  logic handle_acl;
  logic cmd_known;
  logic signed [7:0] slot_rssi;
  logic signed [7:0] rel_db;
  logic [7:0] slot_quality;

  fail_cnt_if cnt_if ();

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  fail_cnt_bank u_fail_cnt_bank (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en),
    .i_flush(i_flush),
    .i_ack(i_ack),
    .i_new_conn(i_new_conn),
    .cnt_if(cnt_if.bank)
  );

  rssi_golden_cmp u_rssi_golden_cmp (
    .i_level_dbm(slot_rssi),
    .o_rel_db(rel_db)
  );

  // ----------------------------------------------------------------
  // Decode of the latched command
  // ----------------------------------------------------------------
  always_comb
  begin
    op_group = op_reg[hci_status_pkg::OGF_LSB +: hci_status_pkg::OGF_W];
    op_cmd = op_reg[hci_status_pkg::OCF_W-1:0];
    handle_id = handle_reg[hci_status_pkg::HANDLE_BITS-1:0];
    slot = handle_id[hci_status_pkg::SLOT_W-1:0];
    handle_reserved = (handle_id > hci_status_pkg::HANDLE_MAX_VALID);
    handle_known = !handle_reserved && (handle_id < hci_status_pkg::HANDLE_SLOTS) && i_conn_active[slot];
    handle_acl = i_conn_is_acl[slot];
    cmd_known = 1'b0;
    if (op_cmd == hci_status_pkg::OCF_READ_FAIL_CNT)
    begin
      cmd_known = 1'b1;
    end
    else if (op_cmd == hci_status_pkg::OCF_RESET_FAIL_CNT)
    begin
      cmd_known = 1'b1;
    end
    else if (op_cmd == hci_status_pkg::OCF_LINK_QUALITY)
    begin
      cmd_known = 1'b1;
    end
    else if (op_cmd == hci_status_pkg::OCF_SIGNAL_STRENGTH)
    begin
      cmd_known = 1'b1;
    end
  end

  assign slot_quality = i_link_quality[slot*8 +: 8];
  assign slot_rssi = i_rssi_dbm[slot*8 +: 8];
  assign cnt_if.sel = slot;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    op_next = op_reg;
    handle_next = handle_reg;
    evt_valid_next = 1'b0;
    evt_opcode_next = evt_opcode_reg;
    evt_status_next = evt_status_reg;
    evt_handle_next = evt_handle_reg;
    evt_value_next = evt_value_reg;
    evt_len_next = evt_len_reg;
    cnt_if.clr = 1'b0;
    case (state_reg)
      hci_status_pkg::ST_IDLE:
      begin
        // Foreign groups are left to other command handlers
        if (i_cmd_valid && (i_cmd_opcode[hci_status_pkg::OGF_LSB +: hci_status_pkg::OGF_W]
            == hci_status_pkg::OGF_STATUS))
        begin
          op_next = i_cmd_opcode;
          handle_next = i_cmd_handle;
          ready_next = 1'b0;
          state_next = hci_status_pkg::ST_EXEC;
        end
      end
      hci_status_pkg::ST_EXEC:
      begin
        evt_opcode_next = op_reg;
        evt_handle_next = handle_reg;
        evt_value_next = hci_status_pkg::COUNT_ZERO;
        evt_len_next = hci_status_pkg::LEN_NONE;
        evt_status_next = hci_status_pkg::ST_SUCCESS;
        if (!cmd_known || (op_group != hci_status_pkg::OGF_STATUS))
        begin
          evt_status_next = hci_status_pkg::ST_UNKNOWN_CMD;
        end
        else if (handle_reserved)
        begin
          evt_status_next = hci_status_pkg::ST_BAD_PARAM;
        end
        else if (!handle_known || !handle_acl)
        begin
          evt_status_next = hci_status_pkg::ST_NO_CONNECTION;
        end
        else if (op_cmd == hci_status_pkg::OCF_READ_FAIL_CNT)
        begin
          evt_value_next = cnt_if.count;
          evt_len_next = hci_status_pkg::LEN_TWO;
        end
        else if (op_cmd == hci_status_pkg::OCF_RESET_FAIL_CNT)
        begin
          cnt_if.clr = 1'b1;
        end
        else if (op_cmd == hci_status_pkg::OCF_LINK_QUALITY)
        begin
          evt_value_next = {8'h00, slot_quality};
          evt_len_next = hci_status_pkg::LEN_ONE;
        end
        else
        begin
          evt_value_next = {{8{rel_db[7]}}, rel_db};
          evt_len_next = hci_status_pkg::LEN_ONE;
        end
        evt_valid_next = i_evt_complete_en;
        done_next = 1'b1;
        state_next = hci_status_pkg::ST_DONE;
      end
      hci_status_pkg::ST_DONE:
      begin
        // One cycle with done high before ready returns for the next command
        ready_next = 1'b1;
        state_next = hci_status_pkg::ST_IDLE;
      end
      default:
      begin
        ready_next = 1'b1;
        state_next = hci_status_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= hci_status_pkg::ST_IDLE;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      op_reg <= 16'h0000;
      handle_reg <= 16'h0000;
      evt_valid_reg <= 1'b0;
      evt_opcode_reg <= 16'h0000;
      evt_status_reg <= 8'h00;
      evt_handle_reg <= 16'h0000;
      evt_value_reg <= 16'h0000;
      evt_len_reg <= 2'h0;
    end
    else if (i_clk_en)
    begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      op_reg <= op_next;
      handle_reg <= handle_next;
      evt_valid_reg <= evt_valid_next;
      evt_opcode_reg <= evt_opcode_next;
      evt_status_reg <= evt_status_next;
      evt_handle_reg <= evt_handle_next;
      evt_value_reg <= evt_value_next;
      evt_len_reg <= evt_len_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_cmd_ready = ready_reg;
  assign o_cmd_done = done_reg;
  assign o_evt_valid = evt_valid_reg;
  assign o_evt_opcode = evt_opcode_reg;
  assign o_evt_status = evt_status_reg;
  assign o_evt_handle = evt_handle_reg;
  assign o_evt_value = evt_value_reg;
  assign o_evt_value_len = evt_len_reg;

endmodule : hci_status_cmds

// ==== tb/hci_status_cmds_props.sv ====
// Purpose: Port checks on the status command block.
// Assumes: One clock domain.
// Notes: Attached to every instance by the bind at the foot.
`timescale 1ns/1ps
module hci_status_cmds_props (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_opcode,
  input wire logic [15:0] i_cmd_handle,
  input wire logic i_evt_complete_en,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_done,
  input wire logic o_evt_valid,
  input wire logic [15:0] o_evt_opcode,
  input wire logic [7:0] o_evt_status,
  input wire logic [15:0] o_evt_handle,
  input wire logic [15:0] o_evt_value,
  input wire logic [1:0] o_evt_value_len
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_taken;
    i_clk_en && o_cmd_ready && i_cmd_valid && i_cmd_opcode[15:10] == 6'h05;
  endsequence
  sequence s_exec;
    s_taken ##1 i_clk_en;
  endsequence
  sequence s_bad_hd;
    i_clk_en && o_cmd_ready && i_cmd_valid && i_cmd_opcode[15:10] == 6'h05 && i_cmd_handle[11:0] > 12'h0EFF
      && i_cmd_opcode[9:0] inside {10'h001, 10'h002, 10'h003, 10'h005};
  endsequence

  property p_done_lat; s_exec |=> o_cmd_done; endproperty
  property p_evt_en; o_cmd_done |-> o_evt_valid == $past(i_evt_complete_en); endproperty
  property p_ready_low; s_taken |=> !o_cmd_ready [*2]; endproperty
  property p_valid_done; o_evt_valid |-> o_cmd_done; endproperty
  property p_done_pulse; o_cmd_done |=> !o_cmd_done; endproperty
  property p_err_len; o_cmd_done && o_evt_status != 8'h00 |-> o_evt_value_len == 2'h0 && o_evt_value == 16'h0000;
  endproperty
  property p_echo;
    s_exec |=> o_evt_handle == $past(i_cmd_handle, 2) && o_evt_opcode == $past(i_cmd_opcode, 2);
  endproperty
  property p_reserved; s_bad_hd ##1 i_clk_en |=> o_evt_status == 8'h12; endproperty
  property p_len_cmd;
    o_cmd_done && o_evt_status == 8'h00 |-> o_evt_value_len ==
      (o_evt_opcode[9:0] == 10'h001 ? 2'h2 : o_evt_opcode[9:0] == 10'h002 ? 2'h0 : 2'h1);
  endproperty
  property p_other_group;
    o_cmd_ready && i_clk_en && i_cmd_valid && i_cmd_opcode[15:10] != 6'h05 |=> o_cmd_ready;
  endproperty
  property p_hold; !o_cmd_done |-> $stable(o_evt_status) && $stable(o_evt_value); endproperty

  a_done_lat: assert property (p_done_lat) else $error("done late");
  a_evt_en: assert property (p_evt_en) else $error("event mask wrong");
  a_ready_low: assert property (p_ready_low) else $error("ready early");
  a_valid_done: assert property (p_valid_done) else $error("event without done");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_err_len: assert property (p_err_len) else $error("error carries value");
  a_echo: assert property (p_echo) else $error("echo wrong");
  a_reserved: assert property (p_reserved) else $error("reserved handle accepted");
  a_len_cmd: assert property (p_len_cmd) else $error("value length wrong");
  a_other_group: assert property (p_other_group) else $error("foreign group taken");
  a_hold: assert property (p_hold) else $error("event data moved");
endmodule : hci_status_cmds_props

bind hci_status_cmds hci_status_cmds_props hci_status_cmds_props_i (.i_clk_sys, .i_arst_n, .i_clk_en,
  .i_cmd_valid, .i_cmd_opcode, .i_cmd_handle, .i_evt_complete_en, .o_cmd_ready, .o_cmd_done, .o_evt_valid,
  .o_evt_opcode, .o_evt_status, .o_evt_handle, .o_evt_value, .o_evt_value_len);

// ==== tb/host_model.sv ====
// Purpose: Host side issuing status commands.
// Assumes: Request changes only at falling edges.
// Notes: Released lines show the inverse of the last value.
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk_sys,
  input wire logic i_cmd_ready,
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_opcode,
  output logic [15:0] o_cmd_handle
);
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_opcode = 16'hFFFF;
    o_cmd_handle = 16'hFFFF;
  end

  task automatic send(input logic [15:0] op, input logic [15:0] hd);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b1;
    o_cmd_opcode = op;
    o_cmd_handle = hd;
    // foreign groups never taken, give up
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end while (!(i_cmd_ready && op[15:10] == 6'h05) && n < 8);
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b0;
    o_cmd_opcode = ~op;
    o_cmd_handle = ~hd;
  endtask : send
endmodule : host_model

// ==== tb/hci_status_cmds_tb.sv ====
// Purpose: Self-checking bench for the status command block.
// Assumes: Clock enable held high.
// Notes: Expected events queued by the driver, checked by a monitor.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module hci_status_cmds_tb;
  typedef struct packed {
    logic v;
    logic [15:0] op;
    logic [7:0] st;
    logic [15:0] hd;
    logic [15:0] val;
    logic [1:0] len;
  } exp_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic evt_en = 1'b1;
  logic [3:0] active = 4'h0, acl = 4'h0, flush = 4'h0, ack = 4'h0, new_conn = 4'h0;
  logic [31:0] quality = 32'h0000_0000, rssi = 32'h0000_0000, seed = 32'h0001_7B3C;
  logic valid, ready, done, evt_v;
  logic [15:0] opcode, handle, evt_op, evt_hd, evt_val;
  logic [7:0] evt_st;
  logic [1:0] len;
  logic [15:0] cnt [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  exp_t q[$];
  int n_mismatch = 0, compares = 0, cycles = 0;

  always #10 clk = ~clk;

  hci_status_cmds hci_status_cmds_i (.i_clk_sys(clk), .i_arst_n(arst_n), .i_clk_en(1'b1), .i_cmd_valid(valid),
    .i_cmd_opcode(opcode), .i_cmd_handle(handle), .i_evt_complete_en(evt_en), .i_conn_active(active),
    .i_conn_is_acl(acl), .i_flush(flush), .i_ack(ack), .i_new_conn(new_conn), .i_link_quality(quality),
    .i_rssi_dbm(rssi), .o_cmd_ready(ready), .o_cmd_done(done), .o_evt_valid(evt_v), .o_evt_opcode(evt_op),
    .o_evt_status(evt_st), .o_evt_handle(evt_hd), .o_evt_value(evt_val), .o_evt_value_len(len));
  host_model host_model_i (.i_clk_sys(clk), .i_cmd_ready(ready), .o_cmd_valid(valid), .o_cmd_opcode(opcode),
    .o_cmd_handle(handle));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic exp_t mk(input logic [9:0] ocf, input logic [15:0] hd, input logic [7:0] st,
    input logic [15:0] val, input logic [1:0] n);
    return '{evt_en, {6'h05, ocf}, st, hd, val, n};
  endfunction : mk

  task automatic results;
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic cmd(input logic [9:0] ocf, input logic [15:0] hd, input exp_t e);
    q.push_back(e);
    host_model_i.send({6'h05, ocf}, hd);
    while (q.size() != 0)
      @(negedge clk);
  endtask : cmd

  task automatic rd(input int s);
    cmd(10'h001, 16'(s), mk(10'h001, 16'(s), 8'h00, cnt[s], 2'h2));
  endtask : rd

  // New link wins; a flush counts one past any ack clear
  task automatic bb(input logic [3:0] f, input logic [3:0] a, input logic [3:0] n);
    @(negedge clk);
    flush = f;
    ack = a;
    new_conn = n;
    for (int i = 0; i < 4; i++)
      cnt[i] = n[i] ? 16'h0000 : f[i] ? (a[i] ? 16'h0001 : cnt[i] + 16'h0001) : a[i] ? 16'h0000 : cnt[i];
    @(negedge clk);
    flush = 4'h0;
    ack = 4'h0;
    new_conn = 4'h0;
  endtask : bb

  always @(negedge clk)
    if (done === 1'b1)
    begin
      if (q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({evt_v, evt_op, evt_st, evt_hd, evt_val, len}, q.pop_front())
    end

  // Whole run needs well under 3000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      results();
    end
  end

  initial
  begin
    logic [7:0] lv [9];
    logic [7:0] rel [9];
    logic [15:0] eh [5];
    logic [7:0] es [5];
    logic [9:0] ops [4];
    lv = '{8'hCE, 8'hE2, 8'hBA, 8'h80, 8'h7F, 8'hC4, 8'hD8, 8'hC3, 8'hD9};
    rel = '{8'h00, 8'h0A, 8'hF6, 8'hBC, 8'h7F, 8'h00, 8'h00, 8'hFF, 8'h01};
    eh = '{16'h0F00, 16'h0FFF, 16'h0EFF, 16'h0002, 16'h0003};
    es = '{8'h12, 8'h12, 8'h02, 8'h02, 8'h02};
    ops = '{10'h001, 10'h002, 10'h003, 10'h005};
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    active = 4'hB;
    acl = 4'h7;
    `CHK({ready, done, evt_v, evt_st, evt_val, len}, {3'b100, 8'h00, 16'h0000, 2'h0})
    // ------------------------------------------------------------
    // Failed-contact counters
    // ------------------------------------------------------------
    repeat (3) bb(4'h1, 4'h0, 4'h0);
    bb(4'h3, 4'h0, 4'h0);
    rd(0);
    cmd(10'h001, 16'h1001, mk(10'h001, 16'h1001, 8'h00, cnt[1], 2'h2));
    bb(4'h1, 4'h3, 4'h0);
    rd(1);
    rd(0);
    bb(4'h3, 4'h0, 4'h1);
    bb(4'h2, 4'h1, 4'h0);
    rd(0);
    cmd(10'h002, 16'h0001, mk(10'h002, 16'h0001, 8'h00, 16'h0000, 2'h0));
    cnt[1] = 16'h0000;
    rd(1);
    // ------------------------------------------------------------
    // Quality and signal strength
    // ------------------------------------------------------------
    for (int i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      quality = seed;
      cmd(10'h003, 16'(i), mk(10'h003, 16'(i), 8'h00, {8'h00, seed[8*i+:8]}, 2'h1));
    end
    for (int i = 0; i < 9; i++)
    begin
      seed = lfsr(seed);
      rssi = {seed[31:8], lv[i]};
      cmd(10'h005, 16'h0000, mk(10'h005, 16'h0000, 8'h00, {{8{rel[i][7]}}, rel[i]}, 2'h1));
    end
    // ------------------------------------------------------------
    // Refusals, masking, foreign group
    // ------------------------------------------------------------
    cmd(10'h004, 16'h0000, mk(10'h004, 16'h0000, 8'h01, 16'h0000, 2'h0));
    for (int i = 0; i < 5; i++)
      cmd(ops[i % 4], eh[i], mk(ops[i % 4], eh[i], es[i], 16'h0000, 2'h0));
    evt_en = 1'b0;
    rd(0);
    evt_en = 1'b1;
    host_model_i.send(16'h0801, 16'h0000);
    `CHK(ready, 1'b1)
    results();
  end
endmodule : hci_status_cmds_tb
